//--- phy_ctl_pkg.sv
// Purpose: shared constants and types of the PHY indicator and strap control block
// Assumes: 10 MHz core clock, registers reached by a plain strobe port
// Notes:   register indices double as port addresses
`default_nettype none
package phy_ctl_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int PIN_W  = 16;
    localparam int IRQ_W  = 4;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] REG_BMCR     = 5'h00;
    localparam logic [ADDR_W-1:0] REG_PCSCFG   = 5'h17;
    localparam logic [ADDR_W-1:0] REG_BYPASS   = 5'h18;
    localparam logic [ADDR_W-1:0] REG_TENSTAT  = 5'h1B;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h1C;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h1D;
    localparam logic [ADDR_W-1:0] REG_PIN_STAT = 5'h1E;

    // ----------------------------------------
    // Field positions, masks and reset values
    // ----------------------------------------
    localparam int BMCR_PD      = 11;
    localparam int BMCR_ISO     = 10;
    localparam int CFG_POL_FDX  = 1;
    localparam int CFG_CLK_DIS  = 7;
    localparam int CFG_COL_LOCK = 11;
    localparam int CFG_REPEAT   = 12;
    localparam int BYP_4B5B     = 14;
    localparam int BYP_ALIGN    = 12;
    localparam int TEN_SERIAL   = 9;
    localparam logic [DATA_W-1:0] BMCR_MASK = 16'h0C00;
    localparam logic [DATA_W-1:0] CFG_MASK  = 16'h1882;
    localparam logic [DATA_W-1:0] BYP_MASK  = 16'h5000;
    localparam logic [DATA_W-1:0] TEN_MASK  = 16'h0200;
    localparam logic [DATA_W-1:0] CFG_RST   = 16'h0080;
    localparam int IRQ_LINK = 0;
    localparam int IRQ_COL  = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_PD   = 3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TICK_TIME_NS    = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int STRETCH_TIME_MS = 40;
    localparam logic [5:0] STRETCH_TICKS = 6'(STRETCH_TIME_MS * 1000000 / TICK_TIME_NS);
    localparam logic [2:0] STRAP_SETTLE  = 3'h6;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {PATH_NIBBLE, PATH_SYMBOL, PATH_SERIAL} path_t;
    typedef enum logic {PH_SETTLE, PH_RUN} phase_t;

    typedef struct packed {
        logic [4:0] phy_addr;
        logic       isolate;
        logic       bp_align;
        logic       bp_4b5b;
        logic       serial;
        logic       mdc;
        logic       tx_clock_mode_strap_lo;
        logic       tx_clock_mode_strap_hi;
        logic       low_power_start_n;
        logic       repeater;
        logic       power_down_in;
        logic       loopback_in;
    } pins_t;

    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic collision;
        logic lock;
        logic link;
        logic full_duplex;
        logic speed_100;
        logic polarity_good;
    } phy_status_t;

    typedef struct packed {
        logic rx_activity_led_n;
        logic link_good_led_n;
        logic duplex_polarity_led_n;
        logic collision_lock_led_n;
    } leds_t;

    typedef struct packed {
        logic       speed_ten_out;
        logic       speed_hundred_out;
        logic       crs;
        logic       loop_100;
        logic       loop_10;
        logic       power_down;
        logic       lowest_power;
        logic       isolate;
        logic       tx_clk_is_output;
        logic       ref_clock_out_oe;
        path_t      path;
        logic [4:0] phy_addr;
    } mode_out_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;
endpackage
`default_nettype wire

//--- phy_status_ctl.sv
// Purpose: indicator, speed, carrier sense, loopback, power-down and strap control of a PHY
// Assumes: pins are asynchronous; status inputs come from logic on clk_i
// Notes:   straps are captured a few cycles after reset release, once filtered
//
// What this block does
// - Receive LED driven low on receive activity and stretched to stay visible.
// - Link LED driven low while a valid link is detected.
// - Duplex LED shows full duplex at 100; at 10 polarity or duplex by config.
// - Collision LED shows stretched collisions or descrambler lock, chosen by config bit.
// - Loopback pin at 100 loops data inside the medium dependent block.
// - Loopback pin at 10 loops data through the ten meg encoder decoder.
// - Low-power start strap keeps low power until next reset or management clock toggle.
// - Power-down pin powers down everything but line impedance while high.
// - Software power-down bit in basic control also powers the device down.
// - Carrier sense is receive only with repeater or full duplex, else receive or transmit.
// - Repeater strap is captured into the configuration register at reset.
// - Speed outputs show ten or hundred megabit configuration.
// - Clock mode strap picks transmit clock direction and reference clock enable.
// - Clearing the clock disable bit enables the reference clock regardless of strap.
// - Reset latches all configuration straps including PHY address and mode straps.
// - At 100 the data path is nibble or five bit symbol.
// - At 10 the data path is nibble or single bit serial.
// - Isolate, bypass, serial, repeater and power-down are set by registers; PHY address, clock mode and low-power start come from straps only.
`timescale 1ns/1ps
`default_nettype none
module phy_status_ctl
    import phy_ctl_pkg::*;
#(
    parameter int TICK_CYCLES = phy_ctl_pkg::TICK_CYCLES_DEF
)(
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire phy_ctl_pkg::pins_t        pins_i,
    input  wire phy_ctl_pkg::phy_status_t  status_i,
    input  wire phy_ctl_pkg::bus_req_t     bus_i,
    output logic [phy_ctl_pkg::DATA_W-1:0] rdata_o,
    output phy_ctl_pkg::leds_t             leds_o,
    output phy_ctl_pkg::leds_t             leds_oe_o,
    output phy_ctl_pkg::mode_out_t         mode_o,
    output logic                           irq_o
);
    import phy_ctl_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0]  s1;
        logic [PIN_W-1:0]  s2;
        logic [PIN_W-1:0]  s3;
        logic [PIN_W-1:0]  filt;
        phase_t            phase;
        logic [2:0]        settle;
        logic              tcm_hi;
        logic              tcm_lo;
        logic              low_power;
        logic              mdc_prev;
        logic [4:0]        phy_addr;
        logic [15:0]       tick_cnt;
        logic              tick;
        logic [5:0]        rx_cnt;
        logic [5:0]        col_cnt;
        logic              link_prev;
        logic              lock_prev;
        logic              col_prev;
        logic              pd_prev;
        logic [DATA_W-1:0] bmcr;
        logic [DATA_W-1:0] cfg_x;
        logic [DATA_W-1:0] bypass;
        logic [DATA_W-1:0] tenstat;
        logic [DATA_W-1:0] rdata;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        leds_t             led_on;
        mode_out_t         mo;
    } state_t;

    state_t           st_r;
    state_t           st_nxt;
    pins_t            pin_f;
    logic [DATA_W-1:0] cfg;
    logic             pd_now;
    logic             col_src;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             wr_hit;

    assign pin_f = pins_t'(st_r.filt);
    // Bits set in CFG_RST held inverted so that an all-zero reset gives the documented default
    assign cfg   = st_r.cfg_x ^ CFG_RST;

    always_comb
    begin
        st_nxt = st_r;
        // --------------------------------
        // Pin synchronisers and filter
        // --------------------------------
        st_nxt.s1   = pins_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));

        // --------------------------------
        // Millisecond tick for stretchers
        // --------------------------------
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt == 16'(TICK_CYCLES - 1))
        begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick     = 1'b1;
        end
        else
        begin
            st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
        end

        // --------------------------------
        // Strap capture and low-power start
        // --------------------------------
        unique case (st_r.phase)
            PH_SETTLE:
            begin
                // Waits for the filter to hold true pin levels before latching
                if (st_r.settle == STRAP_SETTLE - 3'h1)
                begin
                    st_nxt.phase              = PH_RUN;
                    st_nxt.cfg_x[CFG_REPEAT]  = pin_f.repeater ^ CFG_RST[CFG_REPEAT];
                    st_nxt.bmcr[BMCR_ISO]     = pin_f.isolate;
                    st_nxt.bypass[BYP_4B5B]   = pin_f.bp_4b5b;
                    st_nxt.bypass[BYP_ALIGN]  = pin_f.bp_align;
                    st_nxt.tenstat[TEN_SERIAL] = pin_f.serial;
                    st_nxt.phy_addr           = pin_f.phy_addr;
                    st_nxt.tcm_hi             = pin_f.tx_clock_mode_strap_hi;
                    st_nxt.tcm_lo             = pin_f.tx_clock_mode_strap_lo;
                    st_nxt.low_power          = ~pin_f.low_power_start_n;
                    st_nxt.mdc_prev           = pin_f.mdc;
                end
                else
                begin
                    st_nxt.settle = st_r.settle + 3'h1;
                end
            end
            PH_RUN:
            begin
                st_nxt.mdc_prev = pin_f.mdc;
                if (pin_f.mdc != st_r.mdc_prev)
                begin
                    st_nxt.low_power = 1'b0;
                end
            end
        endcase

        // --------------------------------
        // Register writes
        // --------------------------------
        clr = '0;
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                REG_BMCR:     st_nxt.bmcr    = bus_i.wdata & BMCR_MASK;
                REG_PCSCFG:   st_nxt.cfg_x   = (bus_i.wdata & CFG_MASK) ^ CFG_RST;
                REG_BYPASS:   st_nxt.bypass  = bus_i.wdata & BYP_MASK;
                REG_TENSTAT:  st_nxt.tenstat = bus_i.wdata & TEN_MASK;
                REG_IRQ_MASK: st_nxt.irq_mask = bus_i.wdata[IRQ_W-1:0];
                REG_IRQ_STAT: clr = bus_i.wdata[IRQ_W-1:0];
                default:      clr = '0;
            endcase
        end

        // --------------------------------
        // Events and sticky status
        // --------------------------------
        pd_now  = pin_f.power_down_in | st_r.low_power | st_r.bmcr[BMCR_PD];
        col_src = status_i.collision;
        ev[IRQ_LINK] = status_i.link ^ st_r.link_prev;
        ev[IRQ_COL]  = status_i.collision & ~st_r.col_prev;
        ev[IRQ_LOCK] = status_i.lock ^ st_r.lock_prev;
        ev[IRQ_PD]   = (pd_now ^ st_r.pd_prev) & (st_r.phase == PH_RUN);
        st_nxt.link_prev = status_i.link;
        st_nxt.col_prev  = status_i.collision;
        st_nxt.lock_prev = status_i.lock;
        st_nxt.pd_prev   = pd_now;
        // A new event outranks a clear in the same cycle
        st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;

        // --------------------------------
        // Register reads
        // --------------------------------
        st_nxt.rdata = '0;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                REG_BMCR:     st_nxt.rdata = st_r.bmcr;
                REG_PCSCFG:   st_nxt.rdata = cfg;
                REG_BYPASS:   st_nxt.rdata = st_r.bypass;
                REG_TENSTAT:  st_nxt.rdata = st_r.tenstat;
                REG_IRQ_STAT: st_nxt.rdata = {12'h000, st_r.irq_stat};
                REG_IRQ_MASK: st_nxt.rdata = {12'h000, st_r.irq_mask};
                REG_PIN_STAT: st_nxt.rdata = {5'h00, st_r.phy_addr, st_r.tcm_hi, st_r.tcm_lo,
                                              st_r.low_power, pd_now, status_i.speed_100,
                                              st_r.phase == PH_RUN};
                default:      st_nxt.rdata = '0;
            endcase
        end

        // --------------------------------
        // Pulse stretchers
        // --------------------------------
        if (status_i.rx_active)
            st_nxt.rx_cnt = STRETCH_TICKS;
        else if (st_r.tick && st_r.rx_cnt != 6'h00)
            st_nxt.rx_cnt = st_r.rx_cnt - 6'h01;
        if (col_src)
            st_nxt.col_cnt = STRETCH_TICKS;
        else if (st_r.tick && st_r.col_cnt != 6'h00)
            st_nxt.col_cnt = st_r.col_cnt - 6'h01;

        // --------------------------------
        // Indicators
        // --------------------------------
        st_nxt.led_on.rx_activity_led_n = status_i.rx_active | (st_r.rx_cnt != 6'h00);
        st_nxt.led_on.link_good_led_n   = status_i.link;
        if (status_i.speed_100)
            st_nxt.led_on.duplex_polarity_led_n = status_i.full_duplex;
        else if (cfg[CFG_POL_FDX])
            st_nxt.led_on.duplex_polarity_led_n = status_i.full_duplex;
        else
            st_nxt.led_on.duplex_polarity_led_n = status_i.polarity_good;
        if (cfg[CFG_COL_LOCK])
            st_nxt.led_on.collision_lock_led_n = status_i.lock;
        else
            st_nxt.led_on.collision_lock_led_n = col_src | (st_r.col_cnt != 6'h00);

        // --------------------------------
        // Mode outputs
        // --------------------------------
        st_nxt.mo.speed_ten_out     = ~status_i.speed_100;
        st_nxt.mo.speed_hundred_out = status_i.speed_100;
        st_nxt.mo.crs = status_i.rx_active | (status_i.tx_active & ~cfg[CFG_REPEAT]
                        & ~status_i.full_duplex);
        st_nxt.mo.loop_100 = pin_f.loopback_in & status_i.speed_100;
        st_nxt.mo.loop_10  = pin_f.loopback_in & ~status_i.speed_100;
        st_nxt.mo.power_down   = pd_now;
        // The software bit leaves more running, so it does not reach the deepest state
        st_nxt.mo.lowest_power = pin_f.power_down_in | st_r.low_power;
        st_nxt.mo.isolate      = st_r.bmcr[BMCR_ISO];
        st_nxt.mo.tx_clk_is_output = st_r.tcm_lo & ~st_r.tcm_hi;
        st_nxt.mo.ref_clock_out_oe = (st_r.tcm_hi & ~st_r.tcm_lo) | ~cfg[CFG_CLK_DIS];
        if (status_i.speed_100)
            st_nxt.mo.path = (st_r.bypass[BYP_4B5B] | st_r.bypass[BYP_ALIGN])
                             ? PATH_SYMBOL : PATH_NIBBLE;
        else
            st_nxt.mo.path = st_r.tenstat[TEN_SERIAL] ? PATH_SERIAL : PATH_NIBBLE;
        st_nxt.mo.phy_addr = st_r.phy_addr;
        if (st_r.phase == PH_SETTLE)
            st_nxt.mo = '0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rdata_o   = st_r.rdata;
    assign leds_o    = ~st_r.led_on;
    assign leds_oe_o = st_r.led_on;
    assign mode_o    = st_r.mo;
    assign irq_o     = |(st_r.irq_stat & st_r.irq_mask);

    assign wr_hit = bus_i.wr && bus_i.addr == REG_BMCR && bus_i.wdata[BMCR_PD];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_rx_end;
        $fell(status_i.rx_active) && st_r.phase == PH_RUN;
    endsequence
    sequence s_sw_pd_write;
        wr_hit && st_r.phase == PH_RUN;
    endsequence
    // Last settling cycle: straps still sit on the filter outputs
    sequence s_strap_latch;
        st_r.phase == PH_SETTLE && st_nxt.phase == PH_RUN;
    endsequence

    // The edge that ends reset still shows cleared lamps, so lamp checks skip it
    a_rx_led_hold: assert property (!$past(reset_i) && status_i.rx_active
        |=> !leds_o.rx_activity_led_n)
        else $error("rx led not lit on activity");
    a_rx_led_off: assert property (st_r.phase == PH_RUN && !status_i.rx_active
        && st_r.rx_cnt == 6'h00 |=> leds_o.rx_activity_led_n)
        else $error("rx led held after stretch");
    a_rx_stretch_len: assert property (s_rx_end |=> !leds_o.rx_activity_led_n [*8])
        else $error("rx led released too early");
    a_link_led_on: assert property (!$past(reset_i) && status_i.link
        |=> !leds_o.link_good_led_n)
        else $error("link led not lit");
    a_dup_led_100: assert property (!$past(reset_i) && status_i.speed_100
        && status_i.full_duplex
        |=> !leds_o.duplex_polarity_led_n && leds_oe_o.duplex_polarity_led_n)
        else $error("duplex led wrong at 100");
    a_dup_led_ten: assert property (!$past(reset_i) && !status_i.speed_100
        && !cfg[CFG_POL_FDX]
        |=> leds_o.duplex_polarity_led_n == !$past(status_i.polarity_good))
        else $error("polarity led wrong at 10");
    a_col_lock_sel: assert property (cfg[CFG_COL_LOCK] && !status_i.lock
        && !$past(cfg[CFG_COL_LOCK]) == 1'b0 |=> leds_o.collision_lock_led_n)
        else $error("lock mode led wrong");
    a_col_stretch: assert property ($fell(status_i.collision) && !cfg[CFG_COL_LOCK]
        && !$rose(cfg[CFG_COL_LOCK]) |=> !leds_o.collision_lock_led_n [*2])
        else $error("collision not stretched");
    a_loop_hundred: assert property (pin_f.loopback_in && status_i.speed_100
        && st_r.phase == PH_RUN |=> mode_o.loop_100 && !mode_o.loop_10)
        else $error("100 loopback missing");
    a_loop_ten: assert property (pin_f.loopback_in && !status_i.speed_100
        && st_r.phase == PH_RUN |=> mode_o.loop_10)
        else $error("10 loopback missing");
    a_lowpwr_start: assert property (s_strap_latch ##0 !pin_f.low_power_start_n
        |=> ##1 mode_o.lowest_power)
        else $error("low power start not taken");
    a_lowpwr_exit: assert property (st_r.phase == PH_RUN && pin_f.mdc != st_r.mdc_prev
        |=> !st_r.low_power ##1 !$rose(st_r.low_power))
        else $error("low power not left on mdc toggle");
    a_pin_power_down_in: assert property (pin_f.power_down_in && st_r.phase == PH_RUN
        |=> mode_o.power_down && mode_o.lowest_power)
        else $error("power down pin ignored");
    a_sw_power_down_in: assert property (s_sw_pd_write ##1 !bus_i.wr |=> mode_o.power_down)
        else $error("software power down ignored");
    a_crs_repeat: assert property (st_r.phase == PH_RUN && status_i.tx_active
        && !status_i.rx_active && cfg[CFG_REPEAT] |=> !mode_o.crs)
        else $error("carrier sense shows transmit in repeater mode");
    a_repeat_cap: assert property (s_strap_latch
        |=> cfg[CFG_REPEAT] == $past(pin_f.repeater))
        else $error("repeater strap not captured");
    a_speed_out: assert property (st_r.phase == PH_RUN && status_i.speed_100
        |=> mode_o.speed_hundred_out && !mode_o.speed_ten_out)
        else $error("speed outputs wrong");
    a_ref_clk_en: assert property (st_r.phase == PH_RUN && !cfg[CFG_CLK_DIS]
        |=> mode_o.ref_clock_out_oe)
        else $error("reference clock not enabled");
    a_symbol_path: assert property (st_r.phase == PH_RUN && status_i.speed_100
        && st_r.bypass[BYP_4B5B] |=> mode_o.path == PATH_SYMBOL)
        else $error("symbol path not selected");
endmodule // phy_status_ctl
`default_nettype wire

//--- led_pin_model.sv
// Purpose: board side of the open-drain indicator pins, one pull-up each
// Assumes: nothing but the block drives these pins
// Notes:   a released pin reads the pull-up level, never the last driven one
`timescale 1ns/1ps
`default_nettype none
module led_pin_model
    import phy_ctl_pkg::*;
(
    input  wire phy_ctl_pkg::leds_t leds_i,
    input  wire phy_ctl_pkg::leds_t oe_i,
    output var  phy_ctl_pkg::leds_t pin_o
);
    // ----------------------------------------
    // Wire level
    // ----------------------------------------
    assign pin_o = phy_ctl_pkg::leds_t'((oe_i & leds_i) | ~oe_i);
endmodule // led_pin_model
`default_nettype wire

//--- phy_status_ctl_tb.sv
// Purpose: self-checking bench of the indicator and strap control block
// Assumes: short tick of 4 cycles so a stretch lasts 160 cycles
// Notes:   LED levels are judged at the pull-up model; raw outputs are checked at reset, and the link lamp's raw enable in the carrier sense loop
`timescale 1ns/1ps
`default_nettype none
module phy_status_ctl_tb;
    import phy_ctl_pkg::*;
    localparam int TICKS = 4;
    localparam int HOLD  = int'(STRETCH_TICKS) * TICKS;
    logic              clk_i;
    logic              reset_i;
    logic              irq_o;
    logic              lit;
    pins_t             pins;
    phy_status_t       st;
    bus_req_t          bus;
    logic [DATA_W-1:0] rdata;
    leds_t             leds;
    leds_t             leds_oe;
    leds_t             pin_lvl;
    mode_out_t         mode;
    int                errors;
    int                num_checks;

    phy_status_ctl #(.TICK_CYCLES(TICKS)) DUT (.clk_i(clk_i), .reset_i(reset_i), .pins_i(pins),
        .status_i(st), .bus_i(bus), .rdata_o(rdata), .leds_o(leds), .leds_oe_o(leds_oe),
        .mode_o(mode), .irq_o(irq_o));
    led_pin_model lamps (.leds_i(leds), .oe_i(leds_oe), .pin_o(pin_lvl));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i);
        bus <= '{wr:1'b0, rd:1'b1, addr:a, wdata:16'h0000};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic do_reset(input pins_t p);
        @(posedge clk_i);
        pins <= p;
        reset_i <= 1'b1;
        step(5);
        chk(16'({leds, leds_oe}), 16'h00F0);
        @(posedge clk_i) reset_i <= 1'b0;
        step(8);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        errors = 0;
        num_checks = 0;
        reset_i = 1'b1;
        pins = '0;
        st = '0;
        bus = '0;
        do_reset('{phy_addr:5'h15, isolate:1'b1, bp_4b5b:1'b1, serial:1'b1, repeater:1'b1,
            tx_clock_mode_strap_lo:1'b1, low_power_start_n:1'b1, default:1'b0});
        rd(REG_PCSCFG, 16'h1080);
        rd(REG_BMCR, 16'h0400);
        rd(REG_BYPASS, 16'h4000);
        rd(REG_TENSTAT, 16'h0200);
        rd(5'h05, 16'h0000);
        rd(REG_PIN_STAT, 16'h0551);
        chk(16'(mode.phy_addr), 16'h0015);
        chk(16'(mode.isolate), 16'h0001);
        chk(16'({mode.tx_clk_is_output, mode.ref_clock_out_oe}), 16'h0002);
        wr(REG_PCSCFG, 16'h1000);
        step(2);
        chk(16'({mode.tx_clk_is_output, mode.ref_clock_out_oe}), 16'h0003);
        @(posedge clk_i) pins.loopback_in <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk_i) st <= phy_status_t'(s ? 8'h02 : 8'h00);
            step(7);
            chk(16'({mode.speed_hundred_out, mode.speed_ten_out}), s ? 16'h2 : 16'h1);
            chk(16'(mode.path), s ? 16'(PATH_SYMBOL) : 16'(PATH_SERIAL));
            chk(16'({mode.loop_100, mode.loop_10}), s ? 16'h2 : 16'h1);
        end
        @(posedge clk_i) pins.loopback_in <= 1'b0;
        // Duplex lamp over speed, duplex, polarity and the select bit
        for (int i = 0; i < 16; i++)
        begin
            if (i == 8) wr(REG_PCSCFG, 16'h1002);
            @(posedge clk_i) st <= phy_status_t'({5'h00, i[1], i[0], i[2]});
            step(3);
            lit = i[0] ? i[1] : (i[3] ? i[1] : i[2]);
            chk(16'(pin_lvl.duplex_polarity_led_n), 16'(!lit));
        end
        // Carrier sense, repeater bit first set then cleared; link lamp alongside
        for (int i = 0; i < 16; i++)
        begin
            if (i == 8) wr(REG_PCSCFG, 16'h0002);
            @(posedge clk_i) st <= phy_status_t'({i[0], i[1], 2'b00, i[0], i[2], 2'b00});
            step(3);
            chk(16'(mode.crs), 16'(i[0] | (i[1] & i[3] & !i[2])));
            chk(16'({pin_lvl.link_good_led_n, leds_oe.link_good_led_n}),
                i[0] ? 16'h1 : 16'h2);
        end
        // Single-cycle events must stay visible for the stretch time
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i) st <= phy_status_t'(k ? 8'h20 : 8'h80);
            @(posedge clk_i) st <= '0;
            step(HOLD - 10);
            chk(16'(k ? pin_lvl.collision_lock_led_n : pin_lvl.rx_activity_led_n),
                16'h0);
            step(20);
            chk(16'(k ? pin_lvl.collision_lock_led_n : pin_lvl.rx_activity_led_n),
                16'h1);
        end
        wr(REG_PCSCFG, 16'h0800);
        @(posedge clk_i) st.lock <= 1'b1;
        step(3);
        chk(16'(pin_lvl.collision_lock_led_n), 16'h0);
        @(posedge clk_i) pins.power_down_in <= 1'b1;
        step(7);
        chk(16'({mode.power_down, mode.lowest_power}), 16'h3);
        @(posedge clk_i) pins.power_down_in <= 1'b0;
        step(7);
        chk(16'({mode.power_down, mode.lowest_power}), 16'h0);
        wr(REG_BMCR, 16'h0800);
        step(2);
        chk(16'({mode.power_down, mode.lowest_power}), 16'h2);
        // Interrupt: unmasked link change raises it, mask and write-one-clear drop it
        wr(REG_IRQ_MASK, 16'h0001);
        wr(REG_IRQ_STAT, 16'h000F);
        step(1);
        chk(16'(irq_o), 16'h0);
        @(posedge clk_i) st.link <= 1'b1;
        step(3);
        chk(16'(irq_o), 16'h1);
        rd(REG_IRQ_STAT, 16'h0001);
        wr(REG_IRQ_MASK, 16'h0000);
        step(1);
        chk(16'(irq_o), 16'h0);
        wr(REG_IRQ_STAT, 16'h0001);
        rd(REG_IRQ_STAT, 16'h0000);
        // Clock-mode strap codes 0 floating, 1 high, 2 low, all with low-power start
        for (int t = 0; t < 3; t++)
        begin
            do_reset(pins_t'({10'h000, t[1], t[0], 4'h0}));
            chk(16'({mode.tx_clk_is_output, mode.ref_clock_out_oe}), 16'({t[1], t[0]}));
            rd(REG_PCSCFG, 16'h0080);
            chk(16'({mode.power_down, mode.lowest_power}), 16'h3);
            @(posedge clk_i) pins.mdc <= 1'b1;
            step(8);
            chk(16'(mode.lowest_power), 16'h0);
        end
        give_verdict();
    end
endmodule // phy_status_ctl_tb
`default_nettype wire
